/* File: hdl/acq_buffer_formatter.sv */
// acquisition formatter: capture, staging, buffer layout and headers
`timescale 1ns/1ps
`include "acq_params.svh"
module acq_buffer_formatter #(
   parameter int SW = 16,
   parameter int AW = 10,
   parameter int ONBOARD_MEM = 1,
   parameter int STAMP_PRESCALE = `STAMP_PRESCALE_DEF,
   // arbitrary value, stands for the board kind code
   parameter logic [7:0] BOARD_KIND = `BOARD_KIND_DEF
) (
   // clock, reset, enable
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   // ahb-lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // sample stream
   input wire logic SAMPLE_VALID_I,
   input wire logic [SW-1:0] SAMPLE_A_I,
   input wire logic [SW-1:0] SAMPLE_B_I,
   input wire logic [SW-1:0] SAMPLE_C_I,
   input wire logic [SW-1:0] SAMPLE_D_I,
   // trigger sources
   input wire logic TRIG_EXT_I,
   input wire logic TRIG_CHA_I,
   input wire logic TRIG_CHB_I,
   input wire logic TRIG_TIMEOUT_I,
   // dma word stream
   output logic [31:0] DMA_DATA_O,
   output logic DMA_VALID_O,
   output logic DMA_LAST_O,
   input wire logic DMA_READY_I,
   // interrupt
   output logic IRQ_O
);
   import acq_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q, hdr0_q, hdr3_q;
   logic [15:0] spb_q, bufcnt_q, bufs_cap_q, bufs_dr_q;
   logic [3:0] irq_stat_q, irq_mask_q, irq_set;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] rd_mux;
   logic [2:0] ext_sync_q;
   logic ext_level_q, ext_rise, trig_any;
   cap_state_t cap_state_q;
   drain_state_t dr_state_q;
   logic cap_bank_q, dr_bank_q;
   logic [AW-1:0] cap_idx_q, dr_idx_q;
   logic [1:0] full_q, full_set, full_clr;
   logic [`STAMP_W-1:0] stamp_b_q [2];
   logic [3:0] flag_b_q [2];
   logic [23:0] seq_b_q [2];
   logic [23:0] seq_q;
   logic [2:0] dr_ch_q, nch;
   logic [1:0] dr_hw_q;
   logic [`STAMP_W-1:0] stamp_now;
   logic [4*SW-1:0] rd_data;
   logic [31:0] hdr_word;
   logic arm_p, abort_p, stclr_p, stman, ilv, hdr_act, busy;
   logic cap_trig, cap_last, cap_ovf, slot_free, dr_final, dr_fin;
   logic cap_idx_last, dr_idx_last;
   mode_t mode;
   logic [3:0] chen;

   // first enabled channel at or above index s, 3'd4 when none
   function automatic logic [2:0] next_chan(input logic [3:0] m,
                                            input logic [2:0] s);
      logic [2:0] r;
      r = 3'd4;
      for (int i = 3; i >= 0; i--)
         if (m[i] && (3'(i) >= s))
            r = 3'(i);
      return r;
   endfunction

   assign mode = mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
   assign chen = ctrl_q[`CTRL_CHEN_LSB +: 4];
   assign stman = ctrl_q[`CTRL_STMAN];
   assign ilv = ctrl_q[`CTRL_ILV] || (ONBOARD_MEM == 0);
   // headers need staged memory and the contiguous layout
   assign hdr_act = ctrl_q[`CTRL_HDR] && (ONBOARD_MEM != 0) && !ilv
                    && (mode == MODE_MULTI);
   assign busy = (cap_state_q != CAP_IDLE) || (full_q != 2'b00)
                 || (dr_state_q != DR_IDLE);

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
      else if (CE_I)
      begin
         wr_pend_q <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
         wr_addr_q <= HADDR_I[7:0];
         if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I)
            HRDATA_O <= rd_mux;
         else
            HRDATA_O <= 32'h00000000;
      end
   end

   always_comb
   begin
      case (HADDR_I[7:0])
         `REG_CTRL: rd_mux = ctrl_q;
         `REG_SPB: rd_mux = {16'h0000, spb_q};
         `REG_BUFCNT: rd_mux = {16'h0000, bufcnt_q};
         `REG_STATUS: rd_mux = {bufs_dr_q, 9'h000, full_q, busy,
                                dr_state_q, cap_state_q};
         `REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
         `REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
         `REG_HDR0: rd_mux = hdr0_q;
         `REG_HDR3: rd_mux = hdr3_q;
         `REG_PRESCALE: rd_mux = 32'(STAMP_PRESCALE);
         `REG_STAMP_LO: rd_mux = stamp_now[31:0];
         `REG_STAMP_HI: rd_mux = {24'h000000, stamp_now[39:32]};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // write pulses act in the data phase
   assign arm_p = wr_pend_q && (wr_addr_q == `REG_CTRL)
                  && HWDATA_I[`CTRL_ARM] && !busy && (chen != 4'h0);
   assign abort_p = wr_pend_q && (wr_addr_q == `REG_CTRL)
                    && HWDATA_I[`CTRL_ABORT];
   assign stclr_p = wr_pend_q && (wr_addr_q == `REG_CTRL)
                    && HWDATA_I[`CTRL_STCLR];

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         ctrl_q <= `CTRL_RST;
         spb_q <= `SPB_RST;
         bufcnt_q <= `BUFCNT_RST;
         hdr0_q <= 32'h00000000;
         hdr3_q <= 32'h00000000;
         irq_mask_q <= 4'h0;
      end
      else if (CE_I && wr_pend_q)
      begin
         case (wr_addr_q)
            `REG_CTRL: ctrl_q <= HWDATA_I & ~`CTRL_PULSES;
            `REG_SPB: spb_q <= HWDATA_I[15:0];
            `REG_BUFCNT: bufcnt_q <= HWDATA_I[15:0];
            `REG_HDR0: hdr0_q <= HWDATA_I;
            `REG_HDR3: hdr3_q <= HWDATA_I;
            `REG_IRQ_MASK: irq_mask_q <= HWDATA_I[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ----------------------------------------------------------------
   assign irq_set = {cap_trig, cap_ovf,
                     dr_fin && (bufs_dr_q + 16'h0001 == bufcnt_q), dr_fin};

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         irq_stat_q <= 4'h0;
         IRQ_O <= 1'b0;
      end
      else if (CE_I)
      begin
         if (wr_pend_q && (wr_addr_q == `REG_IRQ_STAT))
            irq_stat_q <= (irq_stat_q & ~HWDATA_I[3:0]) | irq_set;
         else
            irq_stat_q <= irq_stat_q | irq_set;
         IRQ_O <= |((irq_stat_q | irq_set) & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // trigger inputs
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         ext_sync_q <= 3'b000;
         ext_level_q <= 1'b0;
      end
      else if (CE_I)
      begin
         ext_sync_q <= {ext_sync_q[1:0], TRIG_EXT_I};
         if (ext_sync_q[2] == ext_sync_q[1])
            ext_level_q <= ext_sync_q[2];
      end
   end

   assign ext_rise = ext_sync_q[2] && ext_sync_q[1] && !ext_level_q;
   assign trig_any = ext_rise || TRIG_CHA_I || TRIG_CHB_I || TRIG_TIMEOUT_I;

   stamp_counter #(
      .PRESCALE(STAMP_PRESCALE)
   ) u_stamp (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .clear_i((arm_p && !stman) || (stclr_p && stman)),
      .count_o(stamp_now)
   );

   // ----------------------------------------------------------------
   // capture side
   // ----------------------------------------------------------------
   assign cap_trig = (cap_state_q == CAP_WAIT) && trig_any
                     && !full_q[cap_bank_q] && !abort_p;
   assign cap_idx_last = ({1'b0, cap_idx_q} == 17'(spb_q) - 17'h1);
   assign cap_last = (cap_state_q == CAP_FILL) && SAMPLE_VALID_I
                     && cap_idx_last && !abort_p;
   // next bank still being drained: stream cannot stay gapless
   assign cap_ovf = (cap_last && (mode != MODE_MULTI)
                     && (bufs_cap_q + 16'h0001 != bufcnt_q)
                     && full_q[!cap_bank_q] && !full_clr[!cap_bank_q])
                    || ((cap_state_q == CAP_WAIT) && trig_any
                        && full_q[cap_bank_q]);
   assign full_set = cap_last ? (2'b01 << cap_bank_q) : 2'b00;

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         cap_state_q <= CAP_IDLE;
         cap_bank_q <= 1'b0;
         cap_idx_q <= '0;
         bufs_cap_q <= 16'h0000;
         seq_q <= 24'h000000;
      end
      else if (CE_I)
      begin
         if (abort_p)
            cap_state_q <= CAP_IDLE;
         else
         begin
            unique case (cap_state_q)
               CAP_IDLE:
                  if (arm_p)
                  begin
                     cap_bank_q <= 1'b0;
                     cap_idx_q <= '0;
                     bufs_cap_q <= 16'h0000;
                     seq_q <= 24'h000000;
                     cap_state_q <= (HWDATA_I[`CTRL_MODE_LSB +: 2]
                        == MODE_CONT) ? CAP_FILL : CAP_WAIT;
                  end
               CAP_WAIT:
                  if (cap_trig)
                  begin
                     seq_q <= seq_q + 24'h000001;
                     cap_state_q <= CAP_FILL;
                  end
               CAP_FILL:
                  if (SAMPLE_VALID_I)
                  begin
                     cap_idx_q <= cap_idx_last ? '0 : cap_idx_q + 1'b1;
                     if (cap_idx_last)
                     begin
                        bufs_cap_q <= bufs_cap_q + 16'h0001;
                        cap_bank_q <= !cap_bank_q;
                        if (bufs_cap_q + 16'h0001 == bufcnt_q || cap_ovf)
                           cap_state_q <= CAP_IDLE;
                        else if (mode == MODE_MULTI)
                           cap_state_q <= CAP_WAIT;
                     end
                  end
               default: cap_state_q <= CAP_IDLE;
            endcase
         end
      end
   end

   // per-bank record facts caught at the trigger
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         stamp_b_q <= '{default: '0};
         flag_b_q <= '{default: 4'h0};
         seq_b_q <= '{default: 24'h000000};
      end
      else if (CE_I && cap_trig)
      begin
         stamp_b_q[cap_bank_q] <= stamp_now;
         flag_b_q[cap_bank_q] <= {TRIG_TIMEOUT_I, TRIG_CHA_I,
                                  TRIG_CHB_I, ext_rise};
         seq_b_q[cap_bank_q] <= seq_q;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         full_q <= 2'b00;
      else if (CE_I)
      begin
         if (abort_p)
            full_q <= 2'b00;
         else
            full_q <= (full_q & ~full_clr) | full_set;
      end
   end

   sample_store #(
      .W(4*SW),
      .AW(AW+1)
   ) u_store (
      .clk_i(CLK_I),
      .ce_i(CE_I),
      .we_i((cap_state_q == CAP_FILL) && SAMPLE_VALID_I),
      .waddr_i({cap_bank_q, cap_idx_q}),
      .wdata_i({SAMPLE_D_I, SAMPLE_C_I, SAMPLE_B_I, SAMPLE_A_I}),
      .re_i(dr_state_q == DR_READ),
      .raddr_i({dr_bank_q, dr_idx_q}),
      .rdata_o(rd_data)
   );

   // ----------------------------------------------------------------
   // header words
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (dr_hw_q)
         2'h0: hdr_word = (hdr0_q & ~(32'h1 << `H0_CHAN_BIT))
                          | (32'(dr_ch_q[0]) << `H0_CHAN_BIT);
         2'h1: hdr_word = {BOARD_KIND, seq_b_q[dr_bank_q]};
         2'h2: hdr_word = stamp_b_q[dr_bank_q][31:0];
         2'h3: hdr_word = {(dr_ch_q == 3'd0) && flag_b_q[dr_bank_q][2]
                           || (dr_ch_q == 3'd1) && flag_b_q[dr_bank_q][1],
                           flag_b_q[dr_bank_q],
                           hdr3_q[`H3_FLAG_LSB-1:8],
                           stamp_b_q[dr_bank_q][39:32]};
      endcase
   end

   // ----------------------------------------------------------------
   // drain side
   // ----------------------------------------------------------------
   assign slot_free = !DMA_VALID_O || DMA_READY_I;
   assign nch = next_chan(chen, dr_ch_q + 3'd1);
   assign dr_idx_last = ({1'b0, dr_idx_q} == 17'(spb_q) - 17'h1);
   assign dr_final = dr_idx_last && nch[2];
   assign dr_fin = (dr_state_q == DR_OUT) && slot_free && dr_final
                   && !abort_p;
   assign full_clr = dr_fin ? (2'b01 << dr_bank_q) : 2'b00;

   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
      begin
         dr_state_q <= DR_IDLE;
         dr_bank_q <= 1'b0;
         dr_idx_q <= '0;
         dr_ch_q <= 3'd0;
         dr_hw_q <= 2'h0;
         bufs_dr_q <= 16'h0000;
         DMA_DATA_O <= 32'h00000000;
         DMA_VALID_O <= 1'b0;
         DMA_LAST_O <= 1'b0;
      end
      else if (CE_I)
      begin
         if (DMA_VALID_O && DMA_READY_I)
         begin
            DMA_VALID_O <= 1'b0;
            DMA_LAST_O <= 1'b0;
         end
         if (abort_p)
         begin
            dr_state_q <= DR_IDLE;
            DMA_VALID_O <= 1'b0;
            DMA_LAST_O <= 1'b0;
         end
         else
         begin
            if (arm_p)
            begin
               dr_bank_q <= 1'b0;
               bufs_dr_q <= 16'h0000;
            end
            unique case (dr_state_q)
               DR_IDLE:
                  if (full_q[dr_bank_q])
                  begin
                     dr_ch_q <= next_chan(chen, 3'd0);
                     dr_idx_q <= '0;
                     dr_hw_q <= 2'h0;
                     dr_state_q <= hdr_act ? DR_HDR : DR_READ;
                  end
               DR_HDR:
                  if (slot_free)
                  begin
                     DMA_DATA_O <= hdr_word;
                     DMA_VALID_O <= 1'b1;
                     dr_hw_q <= dr_hw_q + 2'h1;
                     if (dr_hw_q == `HDR_LAST_WORD)
                        dr_state_q <= DR_READ;
                  end
               DR_READ:
                  dr_state_q <= DR_OUT;
               DR_OUT:
                  if (slot_free)
                  begin
                     DMA_DATA_O <= 32'(rd_data[SW*dr_ch_q[1:0] +: SW]);
                     DMA_VALID_O <= 1'b1;
                     if (dr_final)
                     begin
                        DMA_LAST_O <= 1'b1;
                        dr_bank_q <= !dr_bank_q;
                        bufs_dr_q <= bufs_dr_q + 16'h0001;
                        dr_state_q <= DR_IDLE;
                     end
                     else if (ilv)
                     begin
                        if (!nch[2])
                           dr_ch_q <= nch;
                        else
                        begin
                           dr_ch_q <= next_chan(chen, 3'd0);
                           dr_idx_q <= dr_idx_q + 1'b1;
                           dr_state_q <= DR_READ;
                        end
                     end
                     else if (!dr_idx_last)
                     begin
                        dr_idx_q <= dr_idx_q + 1'b1;
                        dr_state_q <= DR_READ;
                     end
                     else
                     begin
                        dr_ch_q <= nch;
                        dr_idx_q <= '0;
                        dr_hw_q <= 2'h0;
                        dr_state_q <= hdr_act ? DR_HDR : DR_READ;
                     end
                  end
            endcase
         end
      end
   end
endmodule

/* File: pkg/acq_params.svh */
// register map, field positions and reset values for the acquisition formatter
//
// What this block does
// - continuous mode starts filling at arm, no trigger
// - triggered mode waits for trigger, then fills gaplessly
// - fill exactly configured buffers of configured size
// - on-board memory: contiguous block per channel, A..D
// - no memory or interleave: samples interleaved per channel
// - multi-record headers precede each record block
// - per record and channel: header then samples
// - headers only when on-board memory present
// - word 0 holds serial, system, channel, board, format
// - word 1 holds record sequence and board kind
// - words 2 and 3 hold 40-bit timestamp
// - word 3 reports clock, rate, range, coupling, impedance
// - word 3 flags trigger cause bits 27..31
// - 40-bit timestamp counter on prescaled sample clock
// - snapshot timestamp on each capturing trigger
// - timestamp clears at arm unless software-timed clear
// - prescale ratio readable by software
// - multi-record: one post-trigger record per trigger
`ifndef ACQ_PARAMS_SVH
`define ACQ_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_SPB 8'h04
`define REG_BUFCNT 8'h08
`define REG_STATUS 8'h0c
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_HDR0 8'h18
`define REG_HDR3 8'h1c
`define REG_PRESCALE 8'h20
`define REG_STAMP_LO 8'h24
`define REG_STAMP_HI 8'h28

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define CTRL_ARM 0
`define CTRL_ABORT 1
`define CTRL_MODE_LSB 2
`define CTRL_CHEN_LSB 4
`define CTRL_ILV 8
`define CTRL_HDR 9
`define CTRL_STMAN 10
`define CTRL_STCLR 11
`define CTRL_PULSES 32'h00000803
`define CTRL_RST 32'h00000010
`define SPB_RST 16'h0010
`define BUFCNT_RST 16'h0004
`define IRQ_BUF 0
`define IRQ_ACQ 1
`define IRQ_OVF 2
`define IRQ_TRIG 3

// ----------------------------------------------------------------
// record header layout
// ----------------------------------------------------------------
`define HDR_LAST_WORD 2'h3
`define H0_CHAN_BIT 22
`define H3_SET_MASK 32'h07ffff00
`define H3_FLAG_LSB 27
`define STAMP_W 40
`define STAMP_PRESCALE_DEF 2
`define BOARD_KIND_DEF 8'h5a

`endif

/* File: pkg/acq_pkg.sv */
// state and mode types for the acquisition formatter
package acq_pkg;
   typedef enum logic [1:0] {
      MODE_CONT = 2'b00,
      MODE_TRIG = 2'b01,
      MODE_MULTI = 2'b10,
      MODE_SPARE = 2'b11
   } mode_t;
   typedef enum logic [1:0] {
      CAP_IDLE = 2'b00,
      CAP_WAIT = 2'b01,
      CAP_FILL = 2'b10
   } cap_state_t;
   typedef enum logic [1:0] {
      DR_IDLE = 2'b00,
      DR_HDR = 2'b01,
      DR_READ = 2'b10,
      DR_OUT = 2'b11
   } drain_state_t;
endpackage

/* File: hdl/sample_store.sv */
// two-bank staging memory with registered read data
`timescale 1ns/1ps
module sample_store #(
   parameter int W = 64,
   parameter int AW = 11
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic re_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_i)
   begin
      if (ce_i && we_i)
         mem[waddr_i] <= wdata_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (ce_i && re_i)
         rdata_o <= mem[raddr_i];
   end
endmodule

/* File: hdl/stamp_counter.sv */
// 40-bit trigger timestamp counter behind a fixed prescaler
`timescale 1ns/1ps
`include "acq_params.svh"
module stamp_counter #(
   parameter int PRESCALE = `STAMP_PRESCALE_DEF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic clear_i,
   output logic [`STAMP_W-1:0] count_o
);
   logic [7:0] div_q;

   // counts once every PRESCALE sample clocks
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         div_q <= 8'h00;
         count_o <= '0;
      end
      else if (ce_i)
      begin
         if (clear_i)
         begin
            div_q <= 8'h00;
            count_o <= '0;
         end
         else if (div_q == 8'(PRESCALE - 1))
         begin
            div_q <= 8'h00;
            count_o <= count_o + 1'b1;
         end
         else
            div_q <= div_q + 8'h01;
      end
   end
endmodule

/* File: tb/acq_buffer_formatter_assertions.sv */
// port-level concurrent checks for the acquisition formatter
`timescale 1ns/1ps
`include "acq_params.svh"
module acq_checker #(
   parameter int STAMP_PRESCALE = 2
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   // register bus
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   // word stream and interrupt
   input wire logic [31:0] DMA_DATA_O,
   input wire logic DMA_VALID_O,
   input wire logic DMA_LAST_O,
   input wire logic DMA_READY_I,
   input wire logic IRQ_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   logic rd;
   assign rd = HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I && CE_I;
   a_ready_high: assert property (HREADYOUT_O)
      else $error("wait state inserted");
   a_resp_okay: assert property (!HRESP_O)
      else $error("error response");
   a_prescale_read: assert property (rd && HADDR_I[7:0] == `REG_PRESCALE
      |=> HRDATA_O == 32'(STAMP_PRESCALE)) else $error("bad prescale");
   a_pulse_bits: assert property (rd && HADDR_I[7:0] == `REG_CTRL
      |=> HRDATA_O[1:0] == 2'h0) else $error("pulse bits read back");
   a_rdata_idle: assert property (!rd |=> HRDATA_O == 32'h0)
      else $error("read data outside data phase");
   a_word_hold: assert property (DMA_VALID_O && !DMA_READY_I |=>
      DMA_VALID_O && $stable(DMA_DATA_O) && $stable(DMA_LAST_O))
      else $error("word dropped before acceptance");
   a_last_valid: assert property (DMA_LAST_O |-> DMA_VALID_O)
      else $error("last without valid");
   a_reset_quiet: assert property ($rose(RST_N_I) |-> !DMA_VALID_O
      && !IRQ_O && HRDATA_O == 32'h0) else $error("busy out of reset");
   c_last: cover property (DMA_VALID_O && DMA_READY_I && DMA_LAST_O);
   c_stall: cover property (DMA_VALID_O && !DMA_READY_I);
   c_irq: cover property ($rose(IRQ_O));
endmodule

/* File: tb/dma_sink.sv */
// host memory model collecting the formatter's words
`timescale 1ns/1ps
module dma_sink (
   // clock
   input wire logic clk_i,
   // word stream
   input wire logic [31:0] data_i,
   input wire logic valid_i,
   input wire logic last_i,
   input wire logic slow_i,
   output logic ready_o
);
   logic [31:0] q[$];
   logic lq[$];
   initial ready_o = 1'b0;
   always @(posedge clk_i)
   begin
      // slow mode accepts on every other cycle only
      ready_o <= !slow_i || !ready_o;
      if (valid_i && ready_o)
      begin
         q.push_back(data_i);
         lq.push_back(last_i);
      end
   end
endmodule

/* File: tb/acq_buffer_formatter_tb_top.sv */
// self-checking bench for the acquisition formatter
`timescale 1ns/1ps
`include "acq_params.svh"
module acq_buffer_formatter_tb_top;
   logic CLK_I = 0, RST_N_I = 0, HSEL_I = 0, HWRITE_I = 0, slow = 0;
   logic [1:0] HTRANS_I = 0;
   logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O, DMA_DATA_O, rv, s;
   logic HREADYOUT_O, HRESP_O, DMA_VALID_O, DMA_LAST_O, DMA_READY_I, IRQ_O;
   logic SAMPLE_VALID_I = 0, TRIG_CHA_I = 0, TRIG_EXT_I = 0;
   logic [15:0] SAMPLE_A_I = 0, SAMPLE_B_I = 0, SAMPLE_C_I = 0;
   logic [15:0] SAMPLE_D_I = 0, cnt = 0;
   logic [3:0] ph = 0;
   int err_total = 0, checks = 0;
   always #2.5 CLK_I = ~CLK_I;
   // one sample set every 16 cycles, values step by one
   always @(posedge CLK_I)
   begin
      ph <= ph + 4'h1;
      SAMPLE_VALID_I <= ph == 4'h0;
      if (ph == 4'h0)
         cnt <= cnt + 16'h1;
      SAMPLE_A_I <= cnt;
      SAMPLE_B_I <= cnt + 16'h100;
      SAMPLE_C_I <= cnt + 16'h200;
      SAMPLE_D_I <= cnt + 16'h300;
   end
   acq_buffer_formatter uut (.CLK_I, .RST_N_I, .CE_I(1'b1), .HSEL_I,
      .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I(3'h2), .HWDATA_I,
      .HREADY_I(HREADYOUT_O), .HRDATA_O, .HREADYOUT_O, .HRESP_O,
      .SAMPLE_VALID_I, .SAMPLE_A_I, .SAMPLE_B_I, .SAMPLE_C_I, .SAMPLE_D_I,
      .TRIG_EXT_I, .TRIG_CHA_I, .TRIG_CHB_I(1'b0),
      .TRIG_TIMEOUT_I(1'b0), .DMA_DATA_O, .DMA_VALID_O, .DMA_LAST_O,
      .DMA_READY_I, .IRQ_O);
   dma_sink sink (.clk_i(CLK_I), .data_i(DMA_DATA_O), .valid_i(DMA_VALID_O),
      .last_i(DMA_LAST_O), .slow_i(slow), .ready_o(DMA_READY_I));
   task chk(input logic [31:0] sn, input logic [31:0] ex);
      checks++;
      if (sn !== ex)
      begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, sn, ex);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      HSEL_I <= 1'b1;
      HTRANS_I <= 2'h2;
      HWRITE_I <= w;
      HADDR_I <= {24'h0, a};
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      HSEL_I <= 1'b0;
      HTRANS_I <= 2'h0;
      HWDATA_I <= d;
      do @(posedge CLK_I); while (HREADYOUT_O !== 1'b1);
      rv = HRDATA_O;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task waitn(input int n);
      repeat (3000) if (sink.q.size() < n) @(posedge CLK_I);
      chk(32'(sink.q.size()), 32'(n));
   endtask
   task go(input logic [31:0] ctl, input logic [31:0] spb, nb);
      repeat (20) @(posedge CLK_I);
      sink.q.delete();
      sink.lq.delete();
      bus(1'b1, `REG_SPB, spb);
      bus(1'b1, `REG_BUFCNT, nb);
      bus(1'b1, `REG_CTRL, ctl);
   endtask
   task trig;
      @(posedge CLK_I);
      TRIG_CHA_I <= 1'b1;
      @(posedge CLK_I);
      TRIG_CHA_I <= 1'b0;
   endtask
   task t_regs;
      rdc(`REG_CTRL, 32'h10);
      rdc(`REG_SPB, 32'h10);
      rdc(`REG_BUFCNT, 32'h4);
      bus(1'b1, `REG_PRESCALE, 32'h55);
      rdc(`REG_PRESCALE, 32'h2);
      rdc(8'h40, 32'h0);
      bus(1'b0, `REG_STAMP_LO, 32'h0);
      s = rv;
      bus(1'b0, `REG_STAMP_LO, 32'h0);
      chk(rv > s, 1);
   endtask
   task t_cont;
      bus(1'b1, `REG_IRQ_MASK, 32'h2);
      go(32'h11, 3, 2);
      waitn(6);
      for (int i = 0; i < 6; i++)
         chk(sink.q[i], {16'h0, sink.q[0][15:0] + 16'(i)});
      chk({sink.lq[2], sink.lq[5], sink.lq[1]}, 3'b110);
      repeat (200) @(posedge CLK_I);
      chk(32'(sink.q.size()), 6);
      chk(IRQ_O, 1'b1);
      bus(1'b1, `REG_IRQ_STAT, 32'h2);
      repeat (3) @(posedge CLK_I);
      chk(IRQ_O, 1'b0);
      bus(1'b1, `REG_IRQ_STAT, 32'hf);
   endtask
   task t_trig;
      slow <= 1'b1;
      go(32'h35, 2, 2);
      repeat (100) @(posedge CLK_I);
      chk(32'(sink.q.size()), 0);
      trig();
      waitn(8);
      chk(sink.q[1], sink.q[0] + 32'h1);
      chk(sink.q[2], sink.q[0] + 32'h100);
      chk(sink.q[3], sink.q[0] + 32'h101);
      chk(sink.q[4], sink.q[0] + 32'h2);
      chk(sink.q[7], sink.q[0] + 32'h103);
      slow <= 1'b0;
   endtask
   task t_ilv;
      go(32'h151, 2, 1);
      waitn(4);
      chk(sink.q[1], sink.q[0] + 32'h200);
      chk(sink.q[2], sink.q[0] + 32'h1);
      chk(sink.q[3], sink.q[0] + 32'h201);
   endtask
   task t_hdr;
      bus(1'b1, `REG_HDR0, 32'h7fc00123);
      bus(1'b1, `REG_HDR3, 32'hffffffff);
      go(32'h219, 2, 2);
      repeat (40) @(posedge CLK_I);
      trig();
      repeat (200) @(posedge CLK_I);
      TRIG_EXT_I <= 1'b1;
      waitn(12);
      for (int b = 0; b < 12; b += 6)
      begin
         chk(sink.q[b], 32'h7f800123);
         chk(sink.q[b + 1], {`BOARD_KIND_DEF, 24'(b / 6)});
         chk(sink.q[b + 3], b ? 32'h0fffff00
            : 32'ha7ffff00);
         chk(sink.q[b + 5], sink.q[b + 4] + 32'h1);
      end
      chk(sink.q[2] < 32'd40, 1);
      s = sink.q[8] - sink.q[2];
      chk(s >= 32'd101 && s <= 32'd103, 1);
   endtask
   task wrap_up;
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge CLK_I);
      RST_N_I <= 1'b1;
      t_regs();
      t_cont();
      t_trig();
      t_ilv();
      t_hdr();
      wrap_up();
   end
   initial
   begin
      #200000;
      err_total++;
      wrap_up();
   end
endmodule
bind acq_buffer_formatter acq_checker #(.STAMP_PRESCALE(STAMP_PRESCALE))
   chk_i (.CLK_I, .RST_N_I, .CE_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I,
   .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .DMA_DATA_O, .DMA_VALID_O,
   .DMA_LAST_O, .DMA_READY_I, .IRQ_O);
